// File: pkg/mfs_pkg.sv
// Constants, register map and helpers for the frame filter and statistics.
//
// Overview of operation
// - Speed bit selects 100 or 10 Mbit/s.
// - Full duplex ignores collision, carrier; allows receive.
// - Copy-all accepts every valid frame, no filtering.
// - Jumbo enable accepts frames up to 10240 bytes.
// - Broadcast reject discards all-ones destination frames unless copy-all is set.
// - Multicast hash enable accepts on set hash bit.
// - Unicast hash enable accepts on set hash bit.
// - Reject over 1518 bytes; long accept allows 1536.
// - Eight-bit counter counts frames lost to underrun.
// - Underrun frame increments no other counter.
// - Eight-bit counter counts carrier sense error frames.
// - Carrier error counts only in half duplex.
// - Carrier error affects nothing but its counter.
`default_nettype none
package mfs_pkg;
    // ***************************************************************
    // Register byte offsets.
    // ***************************************************************
    localparam logic [7:0] ADR_NCFG = 8'h00;
    localparam logic [7:0] ADR_TX_UNDERRUN_COUNT_FIELD = 8'h04;
    localparam logic [7:0] ADR_CSE = 8'h08;
    localparam logic [7:0] ADR_HASH_LO = 8'h0C;
    localparam logic [7:0] ADR_HASH_HI = 8'h10;
    localparam logic [7:0] ADR_INT_STAT = 8'h14;
    localparam logic [7:0] ADR_INT_MASK = 8'h18;
    // ***************************************************************
    // Network configuration field positions.
    // ***************************************************************
    localparam int B_SPD = 0;
    localparam int B_FD = 1;
    localparam int B_JUMBO = 3;
    localparam int B_CAF = 4;
    localparam int B_NBC = 5;
    localparam int B_MTI = 6;
    localparam int B_UNI = 7;
    localparam int B_BIG = 8;
    localparam logic [31:0] NCFG_WMASK = 32'h0000_01FB;
    // ***************************************************************
    // Interrupt status field positions.
    // ***************************************************************
    localparam int I_UNDERRUN = 0;
    localparam int I_RX_REJECT = 1;
    localparam int I_RX_ACCEPT = 2;
    localparam logic [31:0] INT_WMASK = 32'h0000_0007;
    // ***************************************************************
    // Reset values and frame length limits in bytes.
    // ***************************************************************
    localparam logic [31:0] RST_NCFG = 32'h0000_0000;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [31:0] RST_HASH = 32'h0000_0000;
    localparam logic [31:0] RST_INT = 32'h0000_0000;
    localparam logic [13:0] LEN_NORMAL = 14'd1518;
    localparam logic [13:0] LEN_BIG = 14'd1536;
    localparam logic [13:0] LEN_JUMBO = 14'd10240;

    // Merges write data into a word under the byte enables and a mask.
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] sel,
        input logic [31:0] wmask);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return r & wmask;
    endfunction

    // Six-bit hash: bit i is the XOR of address bits i, i+6, ... i+42.
    function automatic logic [5:0] da_hash(input logic [47:0] da);
        logic [5:0] h;
        h = 6'h00;
        for (int k = 0; k < 8; k++) begin
            h = h ^ da[k*6 +: 6];
        end
        return h;
    endfunction
endpackage
`default_nettype wire

// File: src/mfs_rx_filter.sv
// Receive address and length filter with registered verdict pulses.
`default_nettype none
module mfs_rx_filter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic rx_done,
    input wire logic rx_crc_ok,
    input wire logic [47:0] rx_dest_addr,
    input wire logic [13:0] rx_len,
    input wire logic [31:0] ncfg,
    input wire logic [63:0] hash,
    output logic accept_r,
    output logic reject_r
);
    logic [5:0] hidx;
    logic hit;
    logic bcast;
    logic mcast;
    logic [13:0] max_len;
    logic len_ok;
    logic addr_ok;
    logic ok_nxt;

    // ***************************************************************
    // Verdict decode.
    // ***************************************************************
    always_comb begin
        hidx = mfs_pkg::da_hash(rx_dest_addr);
        hit = hash[hidx];
        bcast = (rx_dest_addr == 48'hFFFF_FFFF_FFFF);
        mcast = rx_dest_addr[0] && !bcast;
        if (ncfg[mfs_pkg::B_JUMBO]) begin
            max_len = mfs_pkg::LEN_JUMBO;
        end else if (ncfg[mfs_pkg::B_BIG]) begin
            max_len = mfs_pkg::LEN_BIG;
        end else begin
            max_len = mfs_pkg::LEN_NORMAL;
        end
        len_ok = (rx_len <= max_len);
        if (ncfg[mfs_pkg::B_CAF]) begin
            addr_ok = 1'b1;
        end else if (bcast) begin
            addr_ok = !ncfg[mfs_pkg::B_NBC];
        end else if (mcast) begin
            addr_ok = ncfg[mfs_pkg::B_MTI] && hit;
        end else begin
            addr_ok = ncfg[mfs_pkg::B_UNI] && hit;
        end
        ok_nxt = rx_crc_ok && len_ok && addr_ok;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            accept_r <= 1'b0;
            reject_r <= 1'b0;
        end else begin
            accept_r <= rx_done && ok_nxt;
            reject_r <= rx_done && !ok_nxt;
        end
    end

    a_oversize_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_done && rx_len > mfs_pkg::LEN_JUMBO |=> reject_r && !accept_r)
        else $error("Oversize frame was not rejected.");
    a_normal_len_limit: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        rx_done && !ncfg[3] && !ncfg[8] && rx_len > 14'd1518 |=> reject_r)
        else $error("Frame over normal limit was accepted.");
    a_bcast_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_done && bcast && ncfg[5] && !ncfg[4] |=> !accept_r)
        else $error("Broadcast frame passed while rejected.");
    a_copy_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_done && ncfg[4] && rx_crc_ok && len_ok |=> accept_r)
        else $error("Copy-all did not accept a valid frame.");
endmodule // mfs_rx_filter
`default_nettype wire

// File: src/mfs_top.sv
// Network configuration, receive filter and transmit statistics block.
//
// Chosen here: the Wishbone slave port and the register offsets.
`default_nettype none
module mfs_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic link_speed_100,
    output logic full_duplex,
    output logic rx_during_tx_en,
    input wire logic phy_col,
    input wire logic phy_crs,
    output logic tx_col_seen,
    output logic tx_crs_seen,
    input wire logic tx_active,
    input wire logic tx_done,
    input wire logic tx_underrun,
    input wire logic rx_done,
    input wire logic rx_crc_ok,
    input wire logic [47:0] rx_dest_addr,
    input wire logic [13:0] rx_len,
    output logic rx_accept,
    output logic rx_reject
);
    logic [31:0] ncfg_r;
    logic [7:0] tx_underrun_count_field_r;
    logic [7:0] cse_r;
    logic [31:0] hash_lo_r;
    logic [31:0] hash_hi_r;
    logic [31:0] int_stat_r;
    logic [31:0] int_mask_r;
    logic crs_seen_r;
    logic crs_lost_r;
    logic col_seen_r;
    logic wr_req;
    logic rd_req;
    logic [31:0] rd_nxt;
    logic underrun_ev;
    logic cse_ev;
    logic crs_drop_now;
    logic [31:0] int_set;
    logic acc_w;
    logic rej_w;
    logic fd;

    assign fd = ncfg_r[mfs_pkg::B_FD];
    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // ***************************************************************
    // Bus slave: one wait state, unmapped reads return zero.
    // ***************************************************************
    always_comb begin
        case (wb_adr_i)
            mfs_pkg::ADR_NCFG: rd_nxt = ncfg_r;
            mfs_pkg::ADR_TX_UNDERRUN_COUNT_FIELD: rd_nxt = {24'h00_0000, tx_underrun_count_field_r};
            mfs_pkg::ADR_CSE: rd_nxt = {24'h00_0000, cse_r};
            mfs_pkg::ADR_HASH_LO: rd_nxt = hash_lo_r;
            mfs_pkg::ADR_HASH_HI: rd_nxt = hash_hi_r;
            mfs_pkg::ADR_INT_STAT: rd_nxt = int_stat_r;
            mfs_pkg::ADR_INT_MASK: rd_nxt = int_mask_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (rd_req) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // ***************************************************************
    // Configuration and hash registers.
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ncfg_r <= mfs_pkg::RST_NCFG;
        end else if (wr_req && wb_adr_i == mfs_pkg::ADR_NCFG) begin
            ncfg_r <= mfs_pkg::wb_merge(ncfg_r, wb_dat_i, wb_sel_i,
                mfs_pkg::NCFG_WMASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hash_lo_r <= mfs_pkg::RST_HASH;
            hash_hi_r <= mfs_pkg::RST_HASH;
        end else if (wr_req) begin
            if (wb_adr_i == mfs_pkg::ADR_HASH_LO) begin
                hash_lo_r <= mfs_pkg::wb_merge(hash_lo_r, wb_dat_i,
                    wb_sel_i, 32'hFFFF_FFFF);
            end
            if (wb_adr_i == mfs_pkg::ADR_HASH_HI) begin
                hash_hi_r <= mfs_pkg::wb_merge(hash_hi_r, wb_dat_i,
                    wb_sel_i, 32'hFFFF_FFFF);
            end
        end
    end

    // ***************************************************************
    // Link mode outputs.
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            link_speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            rx_during_tx_en <= 1'b0;
        end else begin
            link_speed_100 <= ncfg_r[mfs_pkg::B_SPD];
            full_duplex <= fd;
            rx_during_tx_en <= fd;
        end
    end

    // Collision and carrier are hidden from transmit in full duplex.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_col_seen <= 1'b0;
            tx_crs_seen <= 1'b0;
        end else begin
            tx_col_seen <= phy_col && !fd;
            tx_crs_seen <= phy_crs && !fd;
        end
    end

    // ***************************************************************
    // Carrier tracking over one transmitted frame.
    // ***************************************************************
    assign crs_drop_now = crs_seen_r && !phy_crs;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            crs_seen_r <= 1'b0;
            crs_lost_r <= 1'b0;
            col_seen_r <= 1'b0;
        end else if (tx_done || !tx_active) begin
            crs_seen_r <= 1'b0;
            crs_lost_r <= 1'b0;
            col_seen_r <= 1'b0;
        end else begin
            if (phy_crs) begin
                crs_seen_r <= 1'b1;
            end
            if (crs_drop_now) begin
                crs_lost_r <= 1'b1;
            end
            if (phy_col) begin
                col_seen_r <= 1'b1;
            end
        end
    end

    // ***************************************************************
    // Statistics counters.
    // ***************************************************************
    assign underrun_ev = tx_done && tx_underrun;
    assign cse_ev = tx_done && !tx_underrun && !fd && !col_seen_r
        && !phy_col && (!crs_seen_r || crs_lost_r);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_underrun_count_field_r <= mfs_pkg::RST_COUNT;
        end else if (wr_req && wb_adr_i == mfs_pkg::ADR_TX_UNDERRUN_COUNT_FIELD) begin
            tx_underrun_count_field_r <= 8'(mfs_pkg::wb_merge({24'h00_0000, tx_underrun_count_field_r},
                wb_dat_i, wb_sel_i, 32'h0000_00FF));
        end else if (underrun_ev) begin
            tx_underrun_count_field_r <= tx_underrun_count_field_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cse_r <= mfs_pkg::RST_COUNT;
        end else if (wr_req && wb_adr_i == mfs_pkg::ADR_CSE) begin
            cse_r <= 8'(mfs_pkg::wb_merge({24'h00_0000, cse_r},
                wb_dat_i, wb_sel_i, 32'h0000_00FF));
        end else if (cse_ev) begin
            cse_r <= cse_r + 8'h01;
        end
    end

    // ***************************************************************
    // Receive filter.
    // ***************************************************************
    mfs_rx_filter u_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rx_done(rx_done),
        .rx_crc_ok(rx_crc_ok),
        .rx_dest_addr(rx_dest_addr),
        .rx_len(rx_len),
        .ncfg(ncfg_r),
        .hash({hash_hi_r, hash_lo_r}),
        .accept_r(acc_w),
        .reject_r(rej_w)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_accept <= 1'b0;
            rx_reject <= 1'b0;
        end else begin
            rx_accept <= acc_w;
            rx_reject <= rej_w;
        end
    end

    // ***************************************************************
    // Interrupts: sticky status, write one to clear, set wins.
    // ***************************************************************
    always_comb begin
        int_set = 32'h0000_0000;
        int_set[mfs_pkg::I_UNDERRUN] = underrun_ev;
        int_set[mfs_pkg::I_RX_REJECT] = rej_w;
        int_set[mfs_pkg::I_RX_ACCEPT] = acc_w;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_stat_r <= mfs_pkg::RST_INT;
        end else if (wr_req && wb_adr_i == mfs_pkg::ADR_INT_STAT) begin
            int_stat_r <= ((int_stat_r & ~mfs_pkg::wb_merge(32'h0000_0000,
                wb_dat_i, wb_sel_i, mfs_pkg::INT_WMASK)) | int_set);
        end else begin
            int_stat_r <= int_stat_r | int_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_mask_r <= mfs_pkg::RST_INT;
        end else if (wr_req && wb_adr_i == mfs_pkg::ADR_INT_MASK) begin
            int_mask_r <= mfs_pkg::wb_merge(int_mask_r, wb_dat_i,
                wb_sel_i, mfs_pkg::INT_WMASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_stat_r & int_mask_r);
        end
    end

    // ***************************************************************
    // Checks.
    // ***************************************************************
    a_speed_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ##1 link_speed_100 == $past(ncfg_r[0]))
        else $error("Speed output does not follow its bit.");
    a_fd_masks_col: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fd && $past(fd) |-> !tx_col_seen && !tx_crs_seen && rx_during_tx_en)
        else $error("Collision or carrier passed in full duplex.");
    a_tx_underrun_count_field_incr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_done && tx_underrun && !wr_req |=> tx_underrun_count_field_r == $past(tx_underrun_count_field_r) + 8'h01)
        else $error("Underrun counter missed a frame.");
    a_tx_underrun_count_field_alone: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_done && tx_underrun && !wr_req |=> $stable(cse_r))
        else $error("Underrun frame also counted a carrier error.");
    a_cse_never: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_done && !tx_underrun && !fd && !crs_seen_r && !phy_col
        && !col_seen_r && !wr_req |=> cse_r == $past(cse_r) + 8'h01)
        else $error("Missing carrier was not counted.");
    a_cse_fd_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fd && !wr_req |=> $stable(cse_r))
        else $error("Carrier error counted in full duplex.");
    a_cse_no_side: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cse_ev && !wr_req |-> !underrun_ev ##1 $stable(tx_underrun_count_field_r))
        else $error("Carrier error disturbed other state.");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
        |(int_stat_r & int_mask_r) |=> irq_o)
        else $error("Unmasked status did not raise the interrupt.");
    a_ack_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus answer not a single cycle.");
endmodule // mfs_top
`default_nettype wire

// File: tb/mfs_phy_model.sv
// Transceiver model that drives carrier sense and collision to the MAC.
`default_nettype none
module mfs_phy_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tx_active,
    input wire logic [1:0] crs_mode,
    input wire logic col_req,
    output logic phy_crs,
    output logic phy_col
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // Counts the cycles of the current transmit frame.
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !tx_active) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'hF) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // Mode 1 holds carrier all frame, mode 2 drops it early, mode 0 never.
    assign phy_crs = tx_active && (crs_mode == 2'h1
        || (crs_mode == 2'h2 && cnt_r < 4'h3));
    assign phy_col = tx_active && col_req && cnt_r == 4'h2;
endmodule // mfs_phy_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking testbench for the frame filter and statistics block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack_o, irq_o;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic link_speed_100, full_duplex, rx_during_tx_en, fd;
    logic phy_col, phy_crs, tx_crs_seen, tx_active, tx_done, tx_underrun;
    logic tx_col_seen;
    logic rx_done, rx_crc_ok, rx_accept, rx_reject, col_req;
    logic [47:0] rx_dest_addr;
    logic [13:0] rx_len;
    logic [1:0] crs_mode;
    logic [7:0] n_tx_underrun_count_field, n_cse;
    int fail_count, cmp_count, cycles;
    mfs_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link_speed_100(link_speed_100),
        .full_duplex(full_duplex), .rx_during_tx_en(rx_during_tx_en),
        .phy_col(phy_col), .phy_crs(phy_crs), .tx_col_seen(tx_col_seen),
        .tx_crs_seen(tx_crs_seen), .tx_active(tx_active), .tx_done(tx_done),
        .tx_underrun(tx_underrun), .rx_done(rx_done), .rx_crc_ok(rx_crc_ok),
        .rx_dest_addr(rx_dest_addr), .rx_len(rx_len),
        .rx_accept(rx_accept), .rx_reject(rx_reject));
    mfs_phy_model PHY (.sys_clk(sys_clk), .rst_n(rst_n),
        .tx_active(tx_active), .crs_mode(crs_mode), .col_req(col_req),
        .phy_crs(phy_crs), .phy_col(phy_col));
    // ****************************************
    // Clock and cycle limit.
    // ****************************************
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_i <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic tx_frame(input logic und, input logic [1:0] m,
        input logic c);
        logic col_s;
        col_s = 1'h0;
        crs_mode <= m;
        col_req <= c;
        tx_active <= 1'h1;
        repeat (5) begin
            @(posedge sys_clk);
            col_s |= tx_col_seen;
        end
        chk({31'h0, tx_crs_seen}, {31'h0, m == 2'h1 && !fd});
        chk({31'h0, col_s}, {31'h0, c && !fd});
        @(posedge sys_clk);
        tx_done <= 1'h1;
        tx_underrun <= und;
        @(posedge sys_clk);
        tx_done <= 1'h0;
        tx_underrun <= 1'h0;
        tx_active <= 1'h0;
        repeat (2) @(posedge sys_clk);
        if (und) n_tx_underrun_count_field++;
        else if (!fd && m != 2'h1 && !c) n_cse++;
        bus(1'h0, mfs_pkg::ADR_TX_UNDERRUN_COUNT_FIELD, 32'h0);
        chk(rd, {24'h0, n_tx_underrun_count_field});
        bus(1'h0, mfs_pkg::ADR_CSE, 32'h0);
        chk(rd, {24'h0, n_cse});
    endtask
    task automatic rx_case(input logic [47:0] a, input logic [13:0] n,
        input logic ok, input logic exp);
        logic acc, rej;
        acc = 1'h0;
        rej = 1'h0;
        rx_done <= 1'h1;
        rx_dest_addr <= a;
        rx_len <= n;
        rx_crc_ok <= ok;
        @(posedge sys_clk);
        rx_done <= 1'h0;
        repeat (4) begin
            @(posedge sys_clk);
            acc |= rx_accept;
            rej |= rx_reject;
        end
        chk({30'h0, acc, rej}, {30'h0, exp, !exp});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset();
        for (int a = 0; a < 32; a += 4) begin
            bus(1'h0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset value test done");
    endtask
    task automatic t_config();
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'hFFFF_FFFF);
        bus(1'h0, mfs_pkg::ADR_NCFG, 32'h0);
        chk(rd, mfs_pkg::NCFG_WMASK);
        chk({29'h0, link_speed_100, full_duplex, rx_during_tx_en}, 32'h7);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h0);
        chk({29'h0, link_speed_100, full_duplex, rx_during_tx_en}, 32'h0);
        bus(1'h1, 8'h1C, 32'hFFFF_FFFF);
        bus(1'h0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        $display("configuration test done");
    endtask
    task automatic t_tx();
        tx_frame(1'h0, 2'h0, 1'h0);
        tx_frame(1'h0, 2'h2, 1'h0);
        tx_frame(1'h0, 2'h1, 1'h0);
        tx_frame(1'h0, 2'h2, 1'h1);
        bus(1'h0, mfs_pkg::ADR_INT_STAT, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, mfs_pkg::ADR_TX_UNDERRUN_COUNT_FIELD, 32'hFF);
        n_tx_underrun_count_field = 8'hFF;
        tx_frame(1'h1, 2'h0, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h2);
        fd = 1'h1;
        tx_frame(1'h0, 2'h1, 1'h0);
        tx_frame(1'h0, 2'h0, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h0);
        fd = 1'h0;
        $display("transmit statistics test done");
    endtask
    task automatic t_irq();
        bus(1'h0, mfs_pkg::ADR_INT_STAT, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'h1, mfs_pkg::ADR_INT_MASK, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        bus(1'h1, mfs_pkg::ADR_INT_STAT, 32'h1);
        bus(1'h0, mfs_pkg::ADR_INT_STAT, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        $display("interrupt test done");
    endtask
    task automatic t_rx();
        bus(1'h1, mfs_pkg::ADR_HASH_LO, 32'h8);
        bus(1'h1, mfs_pkg::ADR_HASH_HI, 32'h10);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h40);
        rx_case(48'h3, 14'h40, 1'h1, 1'h1);
        rx_case(48'h41, 14'h40, 1'h1, 1'h0);
        rx_case(48'h24, 14'h40, 1'h1, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h80);
        rx_case(48'h24, 14'h40, 1'h1, 1'h1);
        rx_case(48'h22, 14'h40, 1'h1, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h0);
        rx_case(48'hFFFF_FFFF_FFFF, 14'h40, 1'h1, 1'h1);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h20);
        rx_case(48'hFFFF_FFFF_FFFF, 14'h40, 1'h1, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h10);
        rx_case(48'h2, 14'h5EE, 1'h1, 1'h1);
        rx_case(48'h2, 14'h5EF, 1'h1, 1'h0);
        rx_case(48'h2, 14'h40, 1'h0, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h110);
        rx_case(48'h2, 14'h600, 1'h1, 1'h1);
        rx_case(48'h2, 14'h601, 1'h1, 1'h0);
        bus(1'h1, mfs_pkg::ADR_NCFG, 32'h18);
        rx_case(48'h2, 14'h2800, 1'h1, 1'h1);
        rx_case(48'h2, 14'h2801, 1'h1, 1'h0);
        bus(1'h0, mfs_pkg::ADR_INT_STAT, 32'h0);
        chk(rd, 32'h6);
        $display("receive filter test done");
    endtask
    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        {rst_n, wb_cyc, wb_stb, wb_we, tx_active, tx_done} = 6'h0;
        {tx_underrun, rx_done, rx_crc_ok, col_req, fd} = 5'h0;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat_i = 32'h0;
        rx_dest_addr = 48'h0;
        rx_len = 14'h0;
        crs_mode = 2'h0;
        {n_tx_underrun_count_field, n_cse} = 16'h0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'h1;
        @(posedge sys_clk);
        t_reset();
        t_config();
        t_tx();
        t_irq();
        t_rx();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
